//--- hdl/sio_host.sv
/*
 Host controller end: register port for software, drives the pins.
 Assumes CLK is the only clock; main_clk is CLK divided by two.
*/
`timescale 1ns/1ps
module sio_host #(
    parameter int DW = sio_pkg::DW_WIDE,
    parameter int AW = sio_pkg::AW_DEF
) (
    input logic CLK,
    input logic RST,
    input logic [sio_pkg::REG_AW-1:0] ADDR,
    input logic [DW-1:0] WDATA,
    input logic WR,
    input logic RD,
    output logic [DW-1:0] RDATA,
    sio_if.host LNK
);
    import sio_pkg::*;

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_WB0 = 4'b0010,
        H_WB1 = 4'b0100,
        H_RWAIT = 4'b1000
    } sio_hst_t;

    typedef struct packed {
        logic div;
        sio_hst_t st;
        logic go_rd;
        logic go_wr;
        logic mrst;
        logic pll;
        logic [1:0] tmode;
        logic [1:0] tgrp;
        logic [AW-1:0] addr;
        logic [DW-1:0] wd0;
        logic [DW-1:0] wd1;
        logic [DW-1:0] rd0;
        logic [DW-1:0] rd1;
        logic done;
        logic tmo_err;
        logic vprev;
        logic rcnt;
        logic [TMO_W-1:0] tmo;
        logic [AW-1:0] a_q;
        logic rn;
        logic wn;
        logic [DW-1:0] d_q;
        logic wb;
        logic rst_pin;
        logic [DW-1:0] rdata;
    } sio_host_st_t;

    sio_host_st_t s;
    sio_host_st_t n;
    logic busy;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.div = ~s.div;
        // Reset pin launched at falling main_clk, never on a rising one
        if (s.div) n.rst_pin = s.mrst;
        busy = s.st != H_IDLE || s.go_rd || s.go_wr;

        // Status read clears flags; later sets win
        if (RD && ADDR == REG_STAT) begin
            n.done = 1'b0;
            n.tmo_err = 1'b0;
        end

        // Register writes; go bits refused while busy
        if (WR) begin
            if (ADDR == REG_CTRL) begin
                if (!busy) begin
                    n.go_rd = WDATA[CB_GO_RD];
                    n.go_wr = WDATA[CB_GO_WR];
                end
                n.mrst = WDATA[CB_MRST];
                n.pll = WDATA[CB_PLL];
                // Termination changes only while device held
                if (s.mrst) begin
                    n.tmode = WDATA[CB_MODE +: 2];
                    n.tgrp = WDATA[CB_GRP +: 2];
                end
            end else if (ADDR == REG_ADDR) begin
                n.addr = WDATA[AW-1:0];
            end else if (ADDR == REG_WD0) begin
                n.wd0 = WDATA;
            end else if (ADDR == REG_WD1) begin
                n.wd1 = WDATA;
            end
        end

        // Register reads, answer in the next cycle
        if (RD) begin
            if (ADDR == REG_CTRL) begin
                n.rdata = DW'({s.tgrp, s.tmode, s.pll, s.mrst, 2'h0});
            end else if (ADDR == REG_ADDR) begin
                n.rdata = DW'(s.addr);
            end else if (ADDR == REG_WD0) begin
                n.rdata = s.wd0;
            end else if (ADDR == REG_WD1) begin
                n.rdata = s.wd1;
            end else if (ADDR == REG_RD0) begin
                n.rdata = s.rd0;
            end else if (ADDR == REG_RD1) begin
                n.rdata = s.rd1;
            end else if (ADDR == REG_STAT) begin
                n.rdata = DW'({s.tmo_err, s.done, busy});
            end else begin
                n.rdata = '0;
            end
        end

        // Pin sequencer, acts at falling main_clk edges
        if (s.div) begin
            case (s.st)
                H_IDLE: begin
                    if (s.go_wr) begin
                        n.wn = 1'b0;
                        n.a_q = s.addr;
                        n.go_wr = 1'b0;
                        n.st = H_WB0;
                    end else if (s.go_rd) begin
                        n.rn = 1'b0;
                        n.a_q = s.addr;
                        n.go_rd = 1'b0;
                        n.rcnt = 1'b0;
                        n.vprev = 1'b0;
                        n.tmo = '0;
                        n.st = H_RWAIT;
                    end
                end
                H_WB0: begin
                    // Beat 0 with a write clock edge
                    n.wn = 1'b1;
                    n.d_q = s.wd0;
                    n.wb = ~s.wb;
                    n.st = H_WB1;
                end
                H_WB1: begin
                    n.d_q = s.wd1;
                    n.wb = ~s.wb;
                    n.st = H_IDLE;
                end
                H_RWAIT: begin
                    // Beat follows each sample where valid was high
                    n.rn = 1'b1;
                    n.vprev = LNK.rdata_valid[0];
                    n.tmo = s.tmo + 1'b1;
                    if (s.vprev && !s.rcnt) begin
                        n.rd0 = LNK.rdata;
                        n.rcnt = 1'b1;
                    end else if (s.vprev) begin
                        n.rd1 = LNK.rdata;
                        n.done = 1'b1;
                        n.st = H_IDLE;
                    end else if (s.tmo == RD_TMO) begin
                        n.tmo_err = 1'b1;
                        n.st = H_IDLE;
                    end
                end
                default: begin
                    n.st = H_IDLE;
                end
            endcase
        end

        // Synchronous reset; device reset pin held high
        if (RST) begin
            n = '0;
            n.st = H_IDLE;
            n.pll = PLL_RST;
            n.rn = 1'b1;
            n.wn = 1'b1;
            n.rst_pin = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        s <= n;
    end

    // Pins straight from flops
    assign LNK.main_clk = s.div;
    assign LNK.mem_addr_in = s.a_q;
    assign LNK.rd_n = s.rn;
    assign LNK.wr_n = s.wn;
    assign LNK.wdata = s.d_q;
    assign LNK.wbeat_clk = {LANES{s.wb}};
    assign LNK.pll_en = s.pll;
    assign LNK.mem_rst = s.rst_pin;
    assign LNK.term_mode_sel = s.tmode;
    assign LNK.term_group_sel = s.tgrp;
    assign RDATA = s.rdata;
endmodule

//--- include/sio_pkg.sv
/*
 Shared constants for the separate-I/O burst-of-two SRAM link:
 widths, lane split, latency, termination codes, host register map.
 Assumes both ends and the interface import or scope this package.
*/
package sio_pkg;
    // ------------------------------------------------------------
    // Data path shape
    // ------------------------------------------------------------
    localparam int DW_WIDE = 36;
    localparam int DW_NARROW = 18;
    localparam int LANES = 2;
    localparam int AW_DEF = 10;
    localparam int BURST = 2;
    localparam int RD_LAT = 3;
    localparam int MAIN_DIV = 2;

    // ------------------------------------------------------------
    // Termination select codes and resulting levels
    // ------------------------------------------------------------
    localparam int ODT_W = 2;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_STRONG = 2'h1;
    localparam logic [1:0] MODE_WEAK = 2'h2;
    localparam logic [ODT_W-1:0] ODT_OFF = 2'h0;
    localparam logic [ODT_W-1:0] ODT_STRONG = 2'h1;
    localparam logic [ODT_W-1:0] ODT_WEAK = 2'h2;

    // ------------------------------------------------------------
    // Host register indices and control bit positions
    // ------------------------------------------------------------
    localparam int REG_AW = 3;
    localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
    localparam logic [REG_AW-1:0] REG_ADDR = 3'h1;
    localparam logic [REG_AW-1:0] REG_WD0 = 3'h2;
    localparam logic [REG_AW-1:0] REG_WD1 = 3'h3;
    localparam logic [REG_AW-1:0] REG_RD0 = 3'h4;
    localparam logic [REG_AW-1:0] REG_RD1 = 3'h5;
    localparam logic [REG_AW-1:0] REG_STAT = 3'h6;
    localparam int CB_GO_RD = 0;
    localparam int CB_GO_WR = 1;
    localparam int CB_MRST = 2;
    localparam int CB_PLL = 3;
    localparam int CB_MODE = 4;
    localparam int CB_GRP = 6;
    localparam logic PLL_RST = 1'b1;
    localparam int TMO_W = 4;
    localparam logic [TMO_W-1:0] RD_TMO = 4'h8;

    // Level for one input group from mode and inclusion
    function automatic logic [ODT_W-1:0] odt_level(
        input logic [1:0] mode,
        input logic inc
    );
        if (!inc) return ODT_OFF;
        if (mode == MODE_STRONG) return ODT_STRONG;
        if (mode == MODE_WEAK) return ODT_WEAK;
        return ODT_OFF;
    endfunction
endpackage

//--- include/sio_if.sv
/*
 Pin bundle between host controller and SRAM device.
 Assumes the host drives main_clk; all pins are one-way.
*/
`timescale 1ns/1ps
interface sio_if #(
    parameter int DW = sio_pkg::DW_WIDE,
    parameter int AW = sio_pkg::AW_DEF
);
    logic main_clk;
    logic [AW-1:0] mem_addr_in;
    logic rd_n;
    logic wr_n;
    logic [DW-1:0] wdata;
    logic [sio_pkg::LANES-1:0] wbeat_clk;
    logic [DW-1:0] rdata;
    logic [sio_pkg::LANES-1:0] echo_clk;
    logic [sio_pkg::LANES-1:0] rdata_valid;
    logic pll_en;
    logic mem_rst;
    logic [1:0] term_mode_sel;
    logic [1:0] term_group_sel;

    modport dev (
        input main_clk, mem_addr_in, rd_n, wr_n, wdata, wbeat_clk,
        input pll_en, mem_rst, term_mode_sel, term_group_sel,
        output rdata, echo_clk, rdata_valid
    );
    modport host (
        output main_clk, mem_addr_in, rd_n, wr_n, wdata, wbeat_clk,
        output pll_en, mem_rst, term_mode_sel, term_group_sel,
        input rdata, echo_clk, rdata_valid
    );
endinterface

//--- hdl/sio_dev.sv
/*
 SRAM device end: burst-of-two separate-I/O memory on main_clk.
 Assumes the host launches pins half a main_clk period before the
 rising edge and keeps read and write commands two cycles apart.
*/
// Functional notes
// - Addresses sampled on rising main clock edges
// - Write beats captured on each write clock edge
// - Wide part uses all 36 data bits
// - Write lane 0 low half, lane 1 high
// - One read beat per echo clock edge
// - Echo lane 0 low half, lane 1 high
// - Echo clocks toggle freely beside read data
// - Data valid rises half echo cycle early
// - Low read strobe starts a read
// - Low write strobe starts a write
// - Main clock times inputs, core and outputs
// - PLL follows its enable pin
// - Reset high holds device inactive, initial state
// - Mode select: off, strong, weak, reserved
// - Termination selects held static by host
// - Group select adds clocks, address/control
// - Reset disables PLL, ignores strobes
`timescale 1ns/1ps
module sio_dev #(
    parameter int DW = sio_pkg::DW_WIDE,
    parameter int AW = sio_pkg::AW_DEF
) (
    sio_if.dev LNK,
    output logic PLL_ON,
    output logic [sio_pkg::ODT_W-1:0] ODT_DATA,
    output logic [sio_pkg::ODT_W-1:0] ODT_CLK,
    output logic [sio_pkg::ODT_W-1:0] ODT_AC,
    output logic ACTIVE
);
    import sio_pkg::*;

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    localparam int LW = DW / LANES;

    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_B0 = 3'b010,
        W_B1 = 3'b100
    } sio_wst_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic pll_s1;
        logic pll_s2;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic [1:0] grp_s1;
        logic [1:0] grp_s2;
        sio_wst_t wst;
        logic [AW-1:0] waddr;
        logic [DW-1:0] wbuf0;
        logic [DW-1:0] wbuf1;
        logic [LANES-1:0] wb_prev;
        logic [RD_LAT:0] rsr;
        logic [RD_LAT:0][2*DW-1:0] rb;
        logic [DW-1:0] q;
        logic [LANES-1:0] echo;
        logic [LANES-1:0] vld;
        logic pll_on;
        logic [ODT_W-1:0] odt_d;
        logic [ODT_W-1:0] odt_c;
        logic [ODT_W-1:0] odt_a;
        logic active;
    } sio_dev_st_t;

    sio_dev_st_t s;
    sio_dev_st_t n;
    logic [2*DW-1:0] mem [0:(1<<AW)-1];
    logic mem_we;
    logic [2*DW-1:0] mem_wd;
    logic [LANES-1:0] tog;
    logic [DW-1:0] b0_nx;
    logic [DW-1:0] b1_nx;
    logic rd_go;
    logic wr_go;

    // ------------------------------------------------------------
    // Per-lane write beat capture
    // ------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        // Lane clock edge seen as a change since last main edge
        assign tog[g] = LNK.wbeat_clk[g] ^ s.wb_prev[g];
        // Lane slice: low half lane 0, high half lane 1
        assign b0_nx[g*LW +: LW] = (s.wst == W_B0 && tog[g]) ?
            LNK.wdata[g*LW +: LW] : s.wbuf0[g*LW +: LW];
        assign b1_nx[g*LW +: LW] = (s.wst == W_B1 && tog[g]) ?
            LNK.wdata[g*LW +: LW] : s.wbuf1[g*LW +: LW];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_wd = {b1_nx, b0_nx};

        // Two-flop synchronisers for reset and static pins
        n.rst_s1 = LNK.mem_rst;
        n.rst_s2 = s.rst_s1;
        n.pll_s1 = LNK.pll_en;
        n.pll_s2 = s.pll_s1;
        n.mode_s1 = LNK.term_mode_sel;
        n.mode_s2 = s.mode_s1;
        n.grp_s1 = LNK.term_group_sel;
        n.grp_s2 = s.grp_s1;

        n.wb_prev = LNK.wbeat_clk;
        n.wbuf0 = b0_nx;
        n.wbuf1 = b1_nx;

        // Command decode at the main clock edge
        rd_go = !LNK.rd_n && !s.rsr[0];
        wr_go = !LNK.wr_n && s.wst != W_B0;

        // Write burst: command, beat 0, beat 1 then commit
        case (s.wst)
            W_IDLE: begin
                if (wr_go) n.wst = W_B0;
            end
            W_B0: begin
                n.wst = W_B1;
            end
            W_B1: begin
                mem_we = 1'b1;
                n.wst = wr_go ? W_B0 : W_IDLE;
            end
            default: begin
                n.wst = W_IDLE;
            end
        endcase
        if (wr_go) n.waddr = LNK.mem_addr_in;

        // Read pipeline: array word follows its strobe
        n.rsr = {s.rsr[RD_LAT-1:0], rd_go};
        n.rb = {s.rb[RD_LAT-1:0], mem[LNK.mem_addr_in]};
        // Valid leads the first beat by one edge
        n.vld = {LANES{s.rsr[RD_LAT-2] | s.rsr[RD_LAT-1]}};
        // Beat 0 then beat 1, one per echo edge
        if (s.rsr[RD_LAT-1]) begin
            n.q = s.rb[RD_LAT-1][DW-1:0];
        end else if (s.rsr[RD_LAT]) begin
            n.q = s.rb[RD_LAT][2*DW-1:DW];
        end
        // Free-running echo, same flop edge as data
        n.echo = ~s.echo;

        n.pll_on = s.pll_s2;
        // Data always in the group; bit 0 clocks, bit 1 addr/ctl
        n.odt_d = odt_level(s.mode_s2, 1'b1);
        n.odt_c = odt_level(s.mode_s2, s.grp_s2[0]);
        n.odt_a = odt_level(s.mode_s2, s.grp_s2[1]);
        n.active = 1'b1;

        // Reset: inactive, strobes ignored, PLL off
        if (s.rst_s2) begin
            mem_we = 1'b0;
            n.wst = W_IDLE;
            n.waddr = '0;
            n.wbuf0 = '0;
            n.wbuf1 = '0;
            n.rsr = '0;
            n.rb = '0;
            n.q = '0;
            n.echo = '0;
            n.vld = '0;
            n.pll_on = 1'b0;
            n.active = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State and array registers
    // ------------------------------------------------------------
    // Whole state on the link clock
    always_ff @(posedge LNK.main_clk) begin
        s <= n;
    end

    // Array write at the end of a burst
    always_ff @(posedge LNK.main_clk) begin
        if (mem_we) mem[s.waddr] <= mem_wd;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pins and status straight from flops
    assign LNK.rdata = s.q;
    assign LNK.echo_clk = s.echo;
    assign LNK.rdata_valid = s.vld;
    assign PLL_ON = s.pll_on;
    assign ODT_DATA = s.odt_d;
    assign ODT_CLK = s.odt_c;
    assign ODT_AC = s.odt_a;
    assign ACTIVE = s.active;
endmodule

//--- testbench/sio_sva.sv
/*
 Link checker: watches the pins between host and SRAM device.
 Assumes main_clk is made by the host, and the device leaves reset
 a few main_clk edges after mem_rst falls.
*/
`timescale 1ns/1ps
module sio_sva (
    input logic main_clk,
    input logic rd_n,
    input logic wr_n,
    input logic [sio_pkg::LANES-1:0] wbeat_clk,
    input logic [sio_pkg::LANES-1:0] echo_clk,
    input logic [sio_pkg::LANES-1:0] rdata_valid,
    input logic mem_rst,
    input logic [1:0] term_mode_sel,
    input logic [1:0] term_group_sel
);
    import sio_pkg::*;
    // ------------------------------------------------------------
    // Reset shadow
    // ------------------------------------------------------------
    logic [7:0] rst_sh_q = 8'hff;

    // Covers the device's reset synchroniser after mem_rst falls
    always_ff @(posedge main_clk) begin
        rst_sh_q <= {rst_sh_q[6:0], mem_rst};
    end

    default clocking dc @(posedge main_clk); endclocking
    default disable iff (mem_rst || (|rst_sh_q));

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_echo_toggle: assert property (echo_clk == ~$past(echo_clk))
        else $error("echo clock stopped");
    a_lane_match: assert property ((echo_clk[0] == echo_clk[1])
        && (rdata_valid[0] == rdata_valid[1]))
        else $error("read lanes differ");
    a_read_valid: assert property (!rd_n |-> ##3
        (rdata_valid == 2'h3) ##1 (rdata_valid == 2'h3)
        ##1 (rdata_valid == 2'h0))
        else $error("read valid window wrong");
    a_valid_cause: assert property ($rose(rdata_valid[0]) |->
        !$past(rd_n, 3))
        else $error("valid without read");
    a_read_gap: assert property (!rd_n |=> (rd_n && wr_n)[*5])
        else $error("command too soon after read");
    a_write_gap: assert property (!wr_n |=> (rd_n && wr_n)[*2])
        else $error("command too soon after write");
    a_two_beats: assert property (!wr_n |=>
        (wbeat_clk == ~$past(wbeat_clk)) ##1 (wbeat_clk == ~$past(wbeat_clk)))
        else $error("write beats missing");
    a_beat_quiet: assert property ((wbeat_clk != $past(wbeat_clk)) |->
        (!$past(wr_n) || !$past(wr_n, 2)))
        else $error("write clock outside a write");
    a_wbeat_lanes: assert property (wbeat_clk[0] == wbeat_clk[1])
        else $error("write lanes differ");
    a_term_static: assert property ($stable(term_mode_sel)
        && $stable(term_group_sel))
        else $error("termination select moved");
endmodule

//--- testbench/tb_top.sv
/*
 Testbench: host and device joined by the link, driven through the
 host register port. Assumes the package register map and CTRL bits.
*/
`timescale 1ns/1ps
module tb_top;
    import sio_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk;
    logic rst = 1'b1;
    logic [REG_AW-1:0] addr = '0;
    logic [DW_WIDE-1:0] wdat = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DW_WIDE-1:0] rdat, st, x0, x1;
    logic pll_on, active;
    logic [ODT_W-1:0] odt_d, odt_c, odt_a;
    logic [1:0] md = 2'h0;
    logic [1:0] gp = 2'h0;
    logic [DW_WIDE-1:0] wq[$];
    logic [DW_WIDE-1:0] rq[$];
    logic [1:0] pw = 2'h0;
    logic pv = 1'b0;
    int bad_count = 0;
    int samples_checked = 0;
    logic [AW_DEF-1:0] ta [3] = '{10'h000, 10'h3ff, 10'h155};
    logic [DW_WIDE-1:0] td0 [3] = '{36'h9_8765_4321, 36'hf_ffff_ffff,
        36'h0_0003_ffff};
    logic [DW_WIDE-1:0] td1 [3] = '{36'h1_2345_6789, 36'h0_0000_0000,
        36'hf_fffc_0000};

    sio_if lnk();
    sio_host sio_host_i (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdat),
        .WR(wr), .RD(rd), .RDATA(rdat), .LNK(lnk));
    sio_dev sio_dev_i (.LNK(lnk), .PLL_ON(pll_on), .ODT_DATA(odt_d),
        .ODT_CLK(odt_c), .ODT_AC(odt_a), .ACTIVE(active));
    sio_sva sio_sva_i (.main_clk(lnk.main_clk), .rd_n(lnk.rd_n),
        .wr_n(lnk.wr_n), .wbeat_clk(lnk.wbeat_clk), .echo_clk(lnk.echo_clk),
        .rdata_valid(lnk.rdata_valid), .mem_rst(lnk.mem_rst),
        .term_mode_sel(lnk.term_mode_sel),
        .term_group_sel(lnk.term_group_sel));

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Beats seen on the wire, both directions
    always @(posedge lnk.main_clk) begin
        if (lnk.wbeat_clk !== pw) wq.push_back(lnk.wdata);
        if (pv) rq.push_back(lnk.rdata);
        pw = lnk.wbeat_clk;
        pv = lnk.rdata_valid[0];
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DW_WIDE-1:0] ctl(input logic [1:0] go,
        input logic mr, input logic pl);
        return DW_WIDE'({gp, md, pl, mr, go});
    endfunction

    function automatic logic [ODT_W-1:0] exp_odt(input logic [1:0] m,
        input logic inc);
        if (inc && m == 2'h1) return ODT_STRONG;
        if (inc && m == 2'h2) return ODT_WEAK;
        return ODT_OFF;
    endfunction

    task automatic chk(input logic [DW_WIDE-1:0] got,
        input logic [DW_WIDE-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [REG_AW-1:0] a,
        input logic [DW_WIDE-1:0] d);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [REG_AW-1:0] a,
        output logic [DW_WIDE-1:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdat;
    endtask

    // Polls a status bit, bounded
    task automatic wait_stat(input int b, input logic lvl);
        int n;
        n = 0;
        rd_reg(REG_STAT, st);
        while (st[b] !== lvl && n < 200) begin
            rd_reg(REG_STAT, st);
            n++;
        end
        chk(DW_WIDE'(st[b]), DW_WIDE'(lvl));
    endtask

    task automatic settle();
        repeat (16) @(posedge clk);
    endtask

    task automatic conclude();
        $display("checked=%0d bad=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Every mode and group code, set under device reset
        for (int m = 0; m < 4; m++) begin
            for (int g = 0; g < 4; g++) begin
                md = m[1:0];
                gp = g[1:0];
                wr_reg(REG_CTRL, ctl(2'h0, 1'b1, 1'b1));
                wr_reg(REG_CTRL, ctl(2'h0, 1'b1, 1'b1));
                settle();
                chk(DW_WIDE'(active), '0);
                chk(DW_WIDE'(pll_on), '0);
                wr_reg(REG_CTRL, ctl(2'h0, 1'b0, 1'b1));
                settle();
                chk(DW_WIDE'(active), DW_WIDE'(1));
                chk(DW_WIDE'(odt_d), DW_WIDE'(exp_odt(md, 1'b1)));
                chk(DW_WIDE'(odt_c), DW_WIDE'(exp_odt(md, gp[0])));
                chk(DW_WIDE'(odt_a), DW_WIDE'(exp_odt(md, gp[1])));
            end
        end
        // PLL follows its enable
        wr_reg(REG_CTRL, ctl(2'h0, 1'b0, 1'b0));
        settle();
        chk(DW_WIDE'(pll_on), '0);
        wr_reg(REG_CTRL, ctl(2'h0, 1'b0, 1'b1));
        settle();
        chk(DW_WIDE'(pll_on), DW_WIDE'(1));
        // Writes: boundary addresses, lane patterns on the wire
        for (int i = 0; i < 3; i++) begin
            wr_reg(REG_ADDR, DW_WIDE'(ta[i]));
            wr_reg(REG_WD0, td0[i]);
            wr_reg(REG_WD1, td1[i]);
            wq.delete();
            wr_reg(REG_CTRL, ctl(2'h2, 1'b0, 1'b1));
            wait_stat(0, 1'b0);
            chk(DW_WIDE'(wq.size()), DW_WIDE'(2));
            chk(wq[0], td0[i]);
            chk(wq[1], td1[i]);
        end
        // Reads back after all writes
        for (int i = 0; i < 3; i++) begin
            wr_reg(REG_ADDR, DW_WIDE'(ta[i]));
            rq.delete();
            wr_reg(REG_CTRL, ctl(2'h1, 1'b0, 1'b1));
            wait_stat(1, 1'b1);
            rd_reg(REG_RD0, x0);
            rd_reg(REG_RD1, x1);
            chk(x0, td0[i]);
            chk(x1, td1[i]);
            chk(DW_WIDE'(rq.size()), DW_WIDE'(2));
            chk(rq[0], td0[i]);
            chk(rq[1], td1[i]);
        end
        // Unmapped register index
        wr_reg(3'h7, '1);
        rd_reg(3'h7, x0);
        chk(x0, '0);
        // Read strobe while the device is held in reset
        wr_reg(REG_CTRL, ctl(2'h0, 1'b1, 1'b1));
        settle();
        rq.delete();
        wr_reg(REG_CTRL, ctl(2'h1, 1'b1, 1'b1));
        wait_stat(2, 1'b1);
        chk(DW_WIDE'(rq.size()), '0);
        conclude();
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
